/* File: shared/pal_consts.vh */
// constants shared by the palette converter host port design
`ifndef PAL_CONSTS_VH
`define PAL_CONSTS_VH

// ---------------------------------------------------------------
// select pair codes {select_high, select_low}
// ---------------------------------------------------------------
`define PAL_SEL_INDEX 2'b00
`define PAL_SEL_PALETTE 2'b01
`define PAL_SEL_CTRL 2'b10
`define PAL_SEL_MODE 2'b11

// ---------------------------------------------------------------
// configuration register bit positions
// ---------------------------------------------------------------
`define PAL_MR_RESTART 0
`define PAL_MR_RESOLUTION 1
`define PAL_MR_BUS_WIDTH 2
`define PAL_MR_OP_LOW 3
`define PAL_MR_OP_HIGH 4
`define PAL_MR_CALIBRATE 5
`define PAL_MR_MATCH_LOW 6
`define PAL_MR_MATCH_HIGH 7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PAL_MODE_RESET 8'hff
`define PAL_CR1_RESET 8'h00
`define PAL_CR2_RESET 8'hff
`define PAL_CR3_RESET 8'hff
`define PAL_MASK_RESET 8'hff
`define PAL_CTRL_TEST_RESET 3'h0

// ---------------------------------------------------------------
// control register indices
// ---------------------------------------------------------------
`define PAL_IDX_PIXEL_TEST 8'h00
`define PAL_IDX_CONV_TEST 8'h01
`define PAL_IDX_CTRL_TEST 8'h02
`define PAL_IDX_IDENT 8'h03
`define PAL_IDX_PIXEL_MASK 8'h04
`define PAL_IDX_CMD_ONE 8'h05
`define PAL_IDX_CMD_TWO 8'h06
`define PAL_IDX_CMD_THREE 8'h07
`define PAL_IDX_REVISION 8'h0b

// ---------------------------------------------------------------
// command register three fields
// ---------------------------------------------------------------
`define PAL_CR3_PRG_LSB 0
`define PAL_CR3_LOAD_LSB 6

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define PAL_CLK_PERIOD_NS 50
`define PAL_POR_TIME_NS 1000
`define PAL_POR_CYCLES ((`PAL_POR_TIME_NS + `PAL_CLK_PERIOD_NS - 1) / `PAL_CLK_PERIOD_NS)

`endif

/* File: verilog/pal_sync2.v */
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pal_sync2 #(
  parameter W = 1
) (
  ref_clk,
  resetn,
  d_in,
  d_out
);
  input wire ref_clk;
  input wire resetn;
  input wire [W-1:0] d_in;
  output reg [W-1:0] d_out;

  reg [W-1:0] meta_reg; // first stage, read only by the second

  // ---------------------------------------------------------------
  // two stages on the pixel clock
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      meta_reg <= {W{1'b0}};
      d_out <= {W{1'b0}};
    end else begin
      meta_reg <= d_in;
      d_out <= meta_reg;
    end
  end
endmodule // pal_sync2

/* File: verilog/pal_clk_div.v */
// power-of-two clock divider with restart
`timescale 1ns/1ps
module pal_clk_div (
  ref_clk,
  resetn,
  restart,
  div_log2,
  clk_out
);
  input wire ref_clk;
  input wire resetn;
  input wire restart; // forces phase back to start
  input wire [2:0] div_log2; // divide by two to the power of this, at least 1
  output reg clk_out;

  reg [4:0] cnt_reg; // half period counter
  wire [4:0] half_m1; // half period minus one

  // half period is two to the power of div_log2 minus one
  assign half_m1 = (5'h01 << (div_log2 - 3'h1)) - 5'h01;

  // ---------------------------------------------------------------
  // toggle output every half period
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn || restart) begin
      cnt_reg <= 5'h00;
      clk_out <= 1'b0;
    end else if (cnt_reg >= half_m1) begin
      cnt_reg <= 5'h00;
      clk_out <= ~clk_out;
    end else begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end
endmodule // pal_clk_div

/* File: verilog/pal_host_port.v */
// host register port, palette and clock defaults of the palette converter
//
// Functional notes
// - write select pair picks config, index, control
// - read select pair returns config, index, control
// - narrow bus at ten-bit resolution splits colour into two cycles
// - blue write stores triplet, index increments
// - palette read red green blue, then increment
// - reset restarts sampling, sets register defaults
// - reset clocks default to divide 32, 4
// - reset lasts one microsecond, no access
// - index eight bits, readable, writable, auto-increments
// - config reserved top bits read zero
// - write one zero one restarts sampling
// - resolution bit selects ten or eight bits
// - narrow bus treats upper data lines zero
// - normal mode when op bits are zero one
// - calibrate bit rising edge starts calibration
// - unmatched palette select drives outputs zero
// - index zero reads captured red pixel input
// - index one reads red converter input value
// - colour pointer cycles, resets on index write
`timescale 1ns/1ps
`include "pal_consts.vh"
module pal_host_port #(
  parameter [7:0] IDENT_VALUE = 8'h5a, // arbitrary identification value
  parameter [7:0] REVISION_VALUE = 8'h01 // arbitrary revision value
) (
  ref_clk,
  resetn,
  strobe_n,
  read_not_write,
  select_high,
  select_low,
  data_in,
  data_out,
  data_oe,
  palette_select_in_low,
  palette_select_in_high,
  pixel_red,
  pixel_green,
  pixel_blue,
  conv_red,
  conv_green,
  conv_blue,
  video_enable,
  normal_mode,
  calibrate_start,
  pixel_phase,
  por_active,
  programmable_clock_out,
  load_clock_output
);
  input wire ref_clk;
  input wire resetn;
  input wire strobe_n; // host strobe, active low
  input wire read_not_write; // high for read
  input wire select_high;
  input wire select_low;
  input wire [9:0] data_in;
  output reg [9:0] data_out; // read data
  output wire data_oe; // high while the port drives the data lines
  input wire palette_select_in_low;
  input wire palette_select_in_high;
  input wire [7:0] pixel_red;
  input wire [7:0] pixel_green;
  input wire [7:0] pixel_blue;
  output reg [9:0] conv_red; // converter inputs
  output reg [9:0] conv_green;
  output reg [9:0] conv_blue;
  output reg video_enable; // low means outputs drive no current
  output reg normal_mode;
  output reg calibrate_start; // one-cycle pulse
  output reg [1:0] pixel_phase; // sampling phase, zero is first
  output reg por_active;
  output wire programmable_clock_out;
  output wire load_clock_output;

  // colour pointer states
  localparam [2:0] PTR_RED = 3'b001;
  localparam [2:0] PTR_GREEN = 3'b010;
  localparam [2:0] PTR_BLUE = 3'b100;
  // restart sequence states
  localparam [2:0] RS_WAIT_ONE = 3'b001;
  localparam [2:0] RS_WAIT_ZERO = 3'b010;
  localparam [2:0] RS_WAIT_LAST = 3'b100;
  localparam integer POR_CYC_INT = `PAL_POR_CYCLES;
  localparam [4:0] POR_CYC = POR_CYC_INT[4:0]; // counter is five bits wide

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  wire [39:0] pin_s; // synchronised pins
  pal_sync2 #(.W(40)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .d_in({~strobe_n, read_not_write, select_high, select_low, data_in,
      palette_select_in_high, palette_select_in_low, pixel_red, pixel_green, pixel_blue}),
    .d_out(pin_s)
  );
  wire strobe_s = pin_s[39];
  wire rw_s = pin_s[38];
  wire [1:0] sel_s = pin_s[37:36];
  wire [9:0] data_s = pin_s[35:26];
  wire [1:0] ps_s = pin_s[25:24];
  wire [23:0] pix_s = pin_s[23:0];

  // state declarations
  reg strobe_d_reg; // delayed strobe for edge detect
  reg [4:0] por_cnt_reg; // power-on reset length counter
  reg [7:0] mode_reg; // configuration register
  reg [7:0] index_reg; // index pointer
  reg [7:0] cr1_reg;
  reg [7:0] cr2_reg;
  reg [7:0] cr3_reg;
  reg [7:0] mask_reg; // pixel mask
  reg [2:0] ctest_reg; // control test bits
  reg [2:0] ptr_reg; // colour pointer
  reg byte_phase_reg; // second half of a split colour
  reg [7:0] hi_reg; // upper colour bits from first cycle
  reg [9:0] red_hold_reg;
  reg [9:0] green_hold_reg;
  reg [2:0] rs_reg; // restart sequence state
  reg seq_restart_reg; // one-cycle sampling restart
  reg [23:0] pix_cap_reg; // pixel input capture
  reg [29:0] palette_mem [0:255]; // colour palette

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  wire acc = strobe_s & ~strobe_d_reg & ~por_active;
  wire wr_acc = acc & ~rw_s;
  wire rd_acc = acc & rw_s;
  wire bus10 = mode_reg[`PAL_MR_BUS_WIDTH];
  wire res10 = mode_reg[`PAL_MR_RESOLUTION];
  wire split = ~bus10 & res10;
  wire [9:0] din = bus10 ? data_s : {2'b00, data_s[7:0]};
  wire pal_acc = acc & (sel_s == `PAL_SEL_PALETTE);
  wire comp_done = pal_acc & ~(split & ~byte_phase_reg); // a whole component moved
  wire blue_done = comp_done & (ptr_reg == PTR_BLUE);
  wire [29:0] entry = palette_mem[index_reg];
  reg [9:0] wr_comp; // component value being written
  reg [9:0] rd_comp; // component value being read

  // data driven while a read strobe is held
  assign data_oe = strobe_s & rw_s & ~por_active;

  // ---------------------------------------------------------------
  // component select and width shaping
  // ---------------------------------------------------------------
  always @* begin
    if (split) begin
      wr_comp = {hi_reg, data_s[1:0]};
    end else if (res10) begin
      wr_comp = din;
    end else begin
      wr_comp = {din[7:0], 2'b00};
    end
    case (ptr_reg)
      PTR_GREEN: rd_comp = entry[19:10];
      PTR_BLUE: rd_comp = entry[9:0];
      default: rd_comp = entry[29:20];
    endcase
  end

  // ---------------------------------------------------------------
  // palette storage
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (wr_acc && blue_done) begin
      palette_mem[index_reg] <= {red_hold_reg, green_hold_reg, wr_comp};
    end
  end

  // ---------------------------------------------------------------
  // power-on reset interval
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn) begin
      por_cnt_reg <= 5'h00;
      por_active <= 1'b1;
    end else if (por_cnt_reg < POR_CYC - 5'h01) begin
      por_cnt_reg <= por_cnt_reg + 5'h01;
    end else begin
      por_active <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register file and access sequencing
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn || por_active) begin
      strobe_d_reg <= 1'b0;
      mode_reg <= `PAL_MODE_RESET;
      index_reg <= 8'h00;
      cr1_reg <= `PAL_CR1_RESET;
      cr2_reg <= `PAL_CR2_RESET;
      cr3_reg <= `PAL_CR3_RESET;
      mask_reg <= `PAL_MASK_RESET;
      ctest_reg <= `PAL_CTRL_TEST_RESET;
      ptr_reg <= PTR_RED;
      byte_phase_reg <= 1'b0;
      hi_reg <= 8'h00;
      red_hold_reg <= 10'h000;
      green_hold_reg <= 10'h000;
      rs_reg <= RS_WAIT_ONE;
      seq_restart_reg <= 1'b0;
      calibrate_start <= 1'b0;
      data_out <= 10'h000;
    end else begin
      strobe_d_reg <= strobe_s;
      seq_restart_reg <= 1'b0;
      calibrate_start <= 1'b0;
      // configuration register write and its side effects
      if (wr_acc && sel_s == `PAL_SEL_MODE) begin
        mode_reg <= din[7:0];
        calibrate_start <= ~mode_reg[`PAL_MR_CALIBRATE] & din[`PAL_MR_CALIBRATE];
        case (rs_reg)
          RS_WAIT_ONE: begin
            if (din[`PAL_MR_RESTART]) begin
              rs_reg <= RS_WAIT_ZERO;
            end
          end
          RS_WAIT_ZERO: begin
            if (!din[`PAL_MR_RESTART]) begin
              rs_reg <= RS_WAIT_LAST;
            end
          end
          RS_WAIT_LAST: begin
            if (din[`PAL_MR_RESTART]) begin
              seq_restart_reg <= 1'b1;
              rs_reg <= RS_WAIT_ZERO;
            end
          end
          default: rs_reg <= RS_WAIT_ONE;
        endcase
      end
      // index write resets the colour pointer
      if (wr_acc && sel_s == `PAL_SEL_INDEX) begin
        index_reg <= din[7:0];
        ptr_reg <= PTR_RED;
        byte_phase_reg <= 1'b0;
      end
      // indexed control register write, read-only ones ignore it
      if (wr_acc && sel_s == `PAL_SEL_CTRL) begin
        case (index_reg)
          `PAL_IDX_CTRL_TEST: ctest_reg <= din[2:0];
          `PAL_IDX_PIXEL_MASK: mask_reg <= din[7:0];
          `PAL_IDX_CMD_ONE: cr1_reg <= din[7:0];
          `PAL_IDX_CMD_TWO: cr2_reg <= din[7:0];
          `PAL_IDX_CMD_THREE: cr3_reg <= din[7:0];
          default: ;
        endcase
      end
      // first half of a split colour write
      if (wr_acc && pal_acc && split && !byte_phase_reg) begin
        hi_reg <= din[7:0];
      end
      if (pal_acc && split) begin
        byte_phase_reg <= ~byte_phase_reg;
      end
      // component complete: hold it, advance pointer
      if (wr_acc && comp_done && ptr_reg == PTR_RED) begin
        red_hold_reg <= wr_comp;
      end
      if (wr_acc && comp_done && ptr_reg == PTR_GREEN) begin
        green_hold_reg <= wr_comp;
      end
      if (comp_done) begin
        case (ptr_reg)
          PTR_RED: ptr_reg <= PTR_GREEN;
          PTR_GREEN: ptr_reg <= PTR_BLUE;
          default: ptr_reg <= PTR_RED;
        endcase
      end
      if (blue_done) begin
        index_reg <= index_reg + 8'h01;
      end
      // read data
      if (rd_acc) begin
        case (sel_s)
          `PAL_SEL_MODE: data_out <= {2'b00, mode_reg};
          `PAL_SEL_INDEX: data_out <= {2'b00, index_reg};
          `PAL_SEL_CTRL: begin
            case (index_reg)
              `PAL_IDX_PIXEL_TEST: data_out <= {2'b00, pix_cap_reg[23:16]};
              `PAL_IDX_CONV_TEST: data_out <= bus10 ? conv_red : {2'b00, conv_red[9:2]};
              `PAL_IDX_CTRL_TEST: data_out <= {7'h00, ctest_reg};
              `PAL_IDX_IDENT: data_out <= {2'b00, IDENT_VALUE};
              `PAL_IDX_PIXEL_MASK: data_out <= {2'b00, mask_reg};
              `PAL_IDX_CMD_ONE: data_out <= {2'b00, cr1_reg};
              `PAL_IDX_CMD_TWO: data_out <= {2'b00, cr2_reg};
              `PAL_IDX_CMD_THREE: data_out <= {2'b00, cr3_reg};
              `PAL_IDX_REVISION: data_out <= {2'b00, REVISION_VALUE};
              default: data_out <= 10'h000;
            endcase
          end
          default: begin
            if (split && !byte_phase_reg) begin
              data_out <= {2'b00, rd_comp[9:2]};
            end else if (split) begin
              data_out <= {8'h00, rd_comp[1:0]};
            end else if (res10) begin
              data_out <= rd_comp;
            end else begin
              data_out <= {2'b00, rd_comp[9:2]};
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pixel path, diagnostic capture and selection
  // ---------------------------------------------------------------
  wire [7:0] mr = pix_s[23:16] & mask_reg;
  wire [7:0] mg = pix_s[15:8] & mask_reg;
  wire [7:0] mb = pix_s[7:0] & mask_reg;
  wire [29:0] er = palette_mem[mr];
  wire [29:0] eg = palette_mem[mg];
  wire [29:0] eb = palette_mem[mb];
  wire [1:0] lsb_keep = res10 ? 2'b11 : 2'b00;
  wire matched = (ps_s == mode_reg[`PAL_MR_MATCH_HIGH:`PAL_MR_MATCH_LOW]);

  always @(posedge ref_clk) begin
    if (!resetn) begin
      pix_cap_reg <= 24'h000000;
      conv_red <= 10'h000;
      conv_green <= 10'h000;
      conv_blue <= 10'h000;
      video_enable <= 1'b0;
      normal_mode <= 1'b0;
    end else begin
      pix_cap_reg <= pix_s;
      conv_red <= matched ? {er[29:22], er[21:20] & lsb_keep} : 10'h000;
      conv_green <= matched ? {eg[19:12], eg[11:10] & lsb_keep} : 10'h000;
      conv_blue <= matched ? {eb[9:2], eb[1:0] & lsb_keep} : 10'h000;
      video_enable <= matched & ~por_active;
      normal_mode <= ~mode_reg[`PAL_MR_OP_HIGH] & mode_reg[`PAL_MR_OP_LOW];
    end
  end

  // ---------------------------------------------------------------
  // pixel sampling phase
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!resetn || por_active || seq_restart_reg) begin
      pixel_phase <= 2'b00;
    end else begin
      pixel_phase <= pixel_phase + 2'b01;
    end
  end

  // ---------------------------------------------------------------
  // output clocks
  // ---------------------------------------------------------------
  wire [1:0] prg_code = cr3_reg[`PAL_CR3_PRG_LSB+1:`PAL_CR3_PRG_LSB];
  wire [1:0] load_code = cr3_reg[`PAL_CR3_LOAD_LSB+1:`PAL_CR3_LOAD_LSB];
  wire [2:0] prg_log2 = {1'b0, prg_code} + 3'h2; // code three gives divide by 32
  wire [2:0] load_log2 = (load_code == 2'b11) ? 3'h2 : 3'h1; // code three gives four

  pal_clk_div u_prg_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .restart(por_active),
    .div_log2(prg_log2),
    .clk_out(programmable_clock_out)
  );

  pal_clk_div u_load_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .restart(por_active | seq_restart_reg),
    .div_log2(load_log2),
    .clk_out(load_clock_output)
  );
endmodule // pal_host_port

/* File: tb/pal_host_port_asserts.sv */
// concurrent checks on the host port outputs
`timescale 1ns/1ps
module pal_host_port_asserts (
  ref_clk,
  resetn,
  strobe_n,
  read_not_write,
  data_oe,
  por_active,
  pixel_phase,
  calibrate_start,
  video_enable,
  conv_red,
  conv_green,
  conv_blue,
  programmable_clock_out,
  load_clock_output
);
  input logic ref_clk;
  input logic resetn;
  input logic strobe_n;
  input logic read_not_write;
  input logic data_oe;
  input logic por_active;
  input logic [1:0] pixel_phase;
  input logic calibrate_start;
  input logic video_enable;
  input logic [9:0] conv_red;
  input logic [9:0] conv_green;
  input logic [9:0] conv_blue;
  input logic programmable_clock_out;
  input logic load_clock_output;
  // ---------------------------------------------------------------
  // one clock domain, synchronous reset
  // ---------------------------------------------------------------
  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // no bus drive inside the power-on interval
  property p_oe_por; por_active |-> !data_oe; endproperty
  a_oe_por: assert property (p_oe_por) else $error("data driven during power-on");
  // drive only for a synchronised read strobe
  property p_oe_strobe;
    data_oe |-> (!$past(strobe_n, 2) || !$past(strobe_n, 3)) && $past(read_not_write, 2);
  endproperty
  a_oe_strobe: assert property (p_oe_strobe) else $error("data driven without read");
  // sampling starts at the first phase
  property p_por_phase; por_active |-> pixel_phase == 2'h0; endproperty
  a_por_phase: assert property (p_por_phase) else $error("phase not held at start");
  // divided clocks held during power-on
  property p_por_clk; por_active |-> !programmable_clock_out && !load_clock_output; endproperty
  a_por_clk: assert property (p_por_clk) else $error("clock outputs run in power-on");
  // calibration start is a single pulse
  property p_cal_pulse; calibrate_start |=> !calibrate_start; endproperty
  a_cal_pulse: assert property (p_cal_pulse) else $error("calibrate pulse too long");
  // outputs off while in power-on
  property p_video_por; por_active |-> !video_enable; endproperty
  a_video_por: assert property (p_video_por) else $error("video on in power-on");
  // deselected device gives zero converter codes
  property p_conv_off;
    !video_enable && !$past(por_active) |->
      conv_red == 10'h000 && conv_green == 10'h000 && conv_blue == 10'h000;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("converters active when off");
  // phase runs mod four unless restarted to zero
  property p_phase_run;
    !por_active && pixel_phase != $past(pixel_phase) + 2'h1 |-> pixel_phase == 2'h0;
  endproperty
  a_phase_run: assert property (p_phase_run) else $error("phase jumped");
endmodule // pal_host_port_asserts

/* File: tb/pal_host_model.sv */
// behavioural host processor driving the register port
`timescale 1ns/1ps
`include "pal_consts.vh"
module pal_host_model (
  ref_clk,
  por_active,
  strobe_n,
  read_not_write,
  select_high,
  select_low,
  data_in
);
  input wire logic ref_clk;
  input wire logic por_active;
  output logic strobe_n;
  output logic read_not_write;
  output logic select_high;
  output logic select_low;
  output logic [9:0] data_in;
  // idle bus at time zero
  initial begin
    strobe_n = 1'b1;
    read_not_write = 1'b1;
    {select_high, select_low} = 2'b00;
    data_in = 10'h155;
  end
  // one access: strobe low five cycles then high four, request held throughout
  task automatic acc(input logic rw, input logic [1:0] sel, input logic [9:0] d);
    while (por_active !== 1'b0) @(posedge ref_clk);
    @(posedge ref_clk);
    strobe_n <= 1'b0;
    read_not_write <= rw;
    {select_high, select_low} <= sel;
    data_in <= rw ? ~data_in : d;
    repeat (5) @(posedge ref_clk);
    strobe_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    data_in <= ~data_in; // released lines do not keep the old value
  endtask
  // control access: index first, then the register itself
  task automatic ctrl(input logic rw, input logic [7:0] idx, input logic [9:0] d);
    acc(1'b0, `PAL_SEL_INDEX, {2'b00, idx});
    acc(rw, `PAL_SEL_CTRL, d);
  endtask
endmodule // pal_host_model

/* File: tb/pal_host_port_tb.sv */
// self-checking bench for the palette converter host port
`timescale 1ns/1ps
`include "pal_consts.vh"
module pal_host_port_tb;
  // ---------------------------------------------------------------
  // pins and bookkeeping
  // ---------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ps_lo = 1'b1;
  logic ps_hi = 1'b1;
  logic [7:0] pix_r = 8'hff;
  logic [7:0] pix_g = 8'h00;
  logic [7:0] pix_b = 8'h00;
  wire strobe_n, read_not_write, select_high, select_low;
  wire [9:0] data_in, data_out, conv_red, conv_green, conv_blue;
  wire data_oe, video_enable, normal_mode, calibrate_start, por_active;
  wire programmable_clock_out, load_clock_output;
  wire [1:0] pixel_phase;
  logic [9:0] exp_q[$]; // expected read data, oldest first
  int error_cnt = 0;
  int samples_checked = 0;
  int cal_cnt = 0;
  always #25 ref_clk = ~ref_clk;
  pal_host_port #(.IDENT_VALUE(8'h3c)) pal_host_port_inst ( // arbitrary identification value
    .ref_clk(ref_clk), .resetn(resetn), .strobe_n(strobe_n),
    .read_not_write(read_not_write), .select_high(select_high), .select_low(select_low),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .palette_select_in_low(ps_lo), .palette_select_in_high(ps_hi),
    .pixel_red(pix_r), .pixel_green(pix_g), .pixel_blue(pix_b),
    .conv_red(conv_red), .conv_green(conv_green), .conv_blue(conv_blue),
    .video_enable(video_enable), .normal_mode(normal_mode),
    .calibrate_start(calibrate_start), .pixel_phase(pixel_phase), .por_active(por_active),
    .programmable_clock_out(programmable_clock_out), .load_clock_output(load_clock_output));
  pal_host_model pal_host_model_inst (
    .ref_clk(ref_clk), .por_active(por_active), .strobe_n(strobe_n),
    .read_not_write(read_not_write), .select_high(select_high), .select_low(select_low),
    .data_in(data_in));
  // ---------------------------------------------------------------
  // checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [1:0] sel, input logic [9:0] exp);
    exp_q.push_back(exp);
    pal_host_model_inst.acc(1'b1, sel, 10'h000);
  endtask
  task automatic crd(input logic [7:0] idx, input logic [9:0] exp);
    exp_q.push_back(exp);
    pal_host_model_inst.ctrl(1'b1, idx, 10'h000);
  endtask
  task automatic wr(input logic [1:0] sel, input logic [9:0] d);
    pal_host_model_inst.acc(1'b0, sel, d);
  endtask
  // read data is compared once the port lets go of the bus
  always @(negedge data_oe) begin
    #1;
    if (exp_q.size() > 0) chk("read_data", data_out, exp_q.pop_front());
  end
  // count calibration pulses
  always @(posedge ref_clk) if (calibrate_start === 1'b1) cal_cnt++;
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // watchdog: the whole sequence needs about seven hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    stop_test;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n, pc, lc;
    logic p0, l0;
    logic [9:0] v[6];
    void'($urandom(32'hd937));
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    n = 0;
    @(posedge ref_clk);
    #1;
    while (por_active === 1'b1 && n < 100) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk("por_len", 10'(n >= 18 && n <= 21), 10'h001);
    // divided clocks: toggles over 64 cycles
    pc = 0;
    lc = 0;
    repeat (64) begin
      p0 = programmable_clock_out;
      l0 = load_clock_output;
      @(posedge ref_clk);
      #1;
      pc += int'(programmable_clock_out !== p0);
      lc += int'(load_clock_output !== l0);
    end
    chk("prg_clk_toggles", 10'(pc), 10'd4);
    chk("load_clk_toggles", 10'(lc), 10'd32);
    chk("normal_mode", {9'h0, normal_mode}, 10'h000);
    rd(`PAL_SEL_MODE, 10'h0ff);
    crd(`PAL_IDX_CMD_ONE, 10'h000);
    crd(`PAL_IDX_CMD_TWO, 10'h0ff);
    crd(`PAL_IDX_CMD_THREE, 10'h0ff);
    rd(`PAL_SEL_INDEX, 10'h007);
    pal_host_model_inst.ctrl(1'b0, `PAL_IDX_IDENT, 10'h0ff);
    crd(`PAL_IDX_IDENT, 10'h03c);
    crd(8'h20, 10'h000);
    // wide palette: entries ff and 00, wrapping the index
    wr(`PAL_SEL_INDEX, 10'h0ff);
    foreach (v[i]) begin
      v[i] = 10'($urandom);
      wr(`PAL_SEL_PALETTE, v[i]);
    end
    rd(`PAL_SEL_INDEX, 10'h001);
    wr(`PAL_SEL_INDEX, 10'h0ff);
    foreach (v[i]) rd(`PAL_SEL_PALETTE, v[i]);
    rd(`PAL_SEL_INDEX, 10'h001);
    repeat (8) @(posedge ref_clk);
    chk("conv_red", conv_red, v[0]);
    chk("conv_green", conv_green, v[4]);
    chk("conv_blue", conv_blue, v[5]);
    crd(`PAL_IDX_PIXEL_TEST, 10'h0ff);
    crd(`PAL_IDX_CONV_TEST, v[0]);
    // mismatched palette select blanks the outputs
    @(posedge ref_clk);
    ps_lo <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("video_off", {9'h0, video_enable}, 10'h000);
    chk("conv_off", conv_red, 10'h000);
    ps_lo <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("video_on", {9'h0, video_enable}, 10'h001);
    // eight bit resolution forces converter lsbs low
    wr(`PAL_SEL_MODE, 10'h0fd);
    repeat (8) @(posedge ref_clk);
    chk("conv_red_8bit", conv_red, {v[0][9:2], 2'b00});
    // narrow bus, normal mode, calibration and restart
    wr(`PAL_SEL_MODE, 10'h0cb);
    chk("normal_mode", {9'h0, normal_mode}, 10'h001);
    wr(`PAL_SEL_MODE, 10'h0eb);
    chk("cal_pulses", 10'(cal_cnt), 10'h001);
    wr(`PAL_SEL_MODE, 10'h0ea);
    wr(`PAL_SEL_MODE, 10'h0eb);
    #1 chk("phase_restart", {8'h00, pixel_phase}, 10'h001);
    wr(`PAL_SEL_INDEX, 10'h010);
    foreach (v[i]) begin
      if (i < 3) begin
        v[i] = 10'($urandom);
        wr(`PAL_SEL_PALETTE, {2'b11, v[i][9:2]});
        wr(`PAL_SEL_PALETTE, {8'h00, v[i][1:0]});
      end
    end
    wr(`PAL_SEL_INDEX, 10'h010);
    for (int i = 0; i < 3; i++) begin
      rd(`PAL_SEL_PALETTE, {2'b00, v[i][9:2]});
      rd(`PAL_SEL_PALETTE, {8'h00, v[i][1:0]});
    end
    rd(`PAL_SEL_INDEX, 10'h011);
    repeat (10) @(posedge ref_clk);
    chk("pending_reads", 10'(exp_q.size()), 10'h000);
    stop_test;
  end
endmodule // pal_host_port_tb

bind pal_host_port pal_host_port_asserts pal_host_port_asserts_inst (
  .ref_clk(ref_clk), .resetn(resetn), .strobe_n(strobe_n),
  .read_not_write(read_not_write), .data_oe(data_oe), .por_active(por_active),
  .pixel_phase(pixel_phase), .calibrate_start(calibrate_start),
  .video_enable(video_enable), .conv_red(conv_red), .conv_green(conv_green),
  .conv_blue(conv_blue), .programmable_clock_out(programmable_clock_out),
  .load_clock_output(load_clock_output));
